// ===== fwsr_host.sv
// host controller: issues command sequences to the flash and polls status
// assumes flash pins are synchronous to CORE_CLK; ready/busy pulled up outside
// Notes on behaviour
// - every command cycle is a write, except array or identification reads
// - host writes reset after identification or when timeout fail reads high
// - fast program only after bypass entry; bypass exit returns to reads
// - polling valid after final write strobe; program poll at program address
// - after bit 7 turns true host rereads to get all bits valid; this host ignores bit 7 and stops once bit 6 reads the same twice
module fwsr_host
    import fwsr_pkg::*;
(
    input  wire logic                        CORE_CLK,
    input  wire logic                        RESETN,
    input  wire logic                        CMD_VALID,
    input  wire logic [2:0]                  CMD_OP,
    input  wire logic [fwsr_pkg::ADDR_W-1:0] CMD_ADDR,
    input  wire logic [fwsr_pkg::DATA_W-1:0] CMD_DATA,
    output logic                             CMD_READY,
    output logic                             DONE,
    output logic                             FAIL,
    output logic                             SUSPENDED,
    output logic [fwsr_pkg::DATA_W-1:0]      RD_DATA,
    output logic                             BYPASS_ON,
    output logic [fwsr_pkg::ADDR_W-1:0]      FL_ADDR,
    output logic [fwsr_pkg::DATA_W-1:0]      FL_DQ_OUT,
    input  wire logic [fwsr_pkg::DATA_W-1:0] FL_DQ_IN,
    output logic                             FL_DQ_OE,
    output logic                             FL_CE_N,
    output logic                             FL_WE_N,
    output logic                             FL_OE_N,
    input  wire logic                        FL_READY_BUSY_N
);
    import fwsr_pkg::*;

    // ==========================================================
    // sequence table
    fwsr_state_t           state_ff, nxt_state;
    logic [2:0]            op_ff, nxt_op;
    logic [2:0]            step_ff, nxt_step;
    logic [3:0]            cnt_ff, nxt_cnt;
    logic [ADDR_W-1:0]     tgt_addr_ff, nxt_tgt_addr;
    logic [DATA_W-1:0]     tgt_data_ff, nxt_tgt_data;
    logic [DATA_W-1:0]     prev_ff, nxt_prev;
    logic                  have_prev_ff, nxt_have_prev;
    logic                  fail_seen_ff, nxt_fail_seen;
    logic                  bypass_ff, nxt_bypass;
    logic                  erasing_ff, nxt_erasing;
    logic                  susp_ff, nxt_susp;
    logic                  done_ff, nxt_done;
    logic                  fail_ff, nxt_fail;
    logic [DATA_W-1:0]     rd_ff, nxt_rd;
    logic [ADDR_W-1:0]     addr_ff, nxt_addr;
    logic [DATA_W-1:0]     dq_ff, nxt_dq;
    logic                  oe_ff, nxt_oe;
    logic                  ce_n_ff, nxt_ce_n;
    logic                  we_n_ff, nxt_we_n;
    logic                  rd_n_ff, nxt_rd_n;
    logic [2:0]            nsteps;
    logic [ADDR_W-1:0]     s_addr;
    logic [7:0]            s_data;
    logic                  op_ok;
    logic                  poll_done;

    // number of write cycles per operation
    always_comb begin
        nsteps = 3'd1;
        case (op_ff)
            OP_PROGRAM:      nsteps = bypass_ff ? 3'd2 : 3'd4;
            OP_SECTOR_ERASE: nsteps = 3'd6;
            OP_CHIP_ERASE:   nsteps = 3'd6;
            OP_BYPASS_ON:    nsteps = 3'd3;
            OP_BYPASS_OFF:   nsteps = 3'd2;
            default:         nsteps = 3'd1;
        endcase
    end

    // address/data of each write cycle; upper data lines driven zero as don't care
    always_comb begin
        s_addr = UNLOCK_ADDR1;
        s_data = CMD_RESET;
        case (op_ff)
            OP_SUSPEND: s_data = CMD_SUSPEND;
            OP_RESUME:  s_data = CMD_RESUME;
            OP_RESET:   s_data = CMD_RESET;
            OP_BYPASS_OFF: s_data = (step_ff == 3'd0) ? CMD_AUTOSELECT : CMD_BYPASS_EXIT;
            default: begin
                if (op_ff == OP_PROGRAM && bypass_ff) begin
                    s_data = CMD_PROGRAM;
                    if (step_ff == 3'd1) begin
                        s_addr = tgt_addr_ff;
                    end
                end else begin
                    case (step_ff)
                        3'd0, 3'd3: s_data = UNLOCK_DATA1;
                        3'd1, 3'd4: begin
                            s_data = UNLOCK_DATA2;
                            s_addr = UNLOCK_ADDR2;
                        end
                        3'd2: begin
                            case (op_ff)
                                OP_PROGRAM:   s_data = CMD_PROGRAM;
                                OP_BYPASS_ON: s_data = CMD_BYPASS;
                                default:      s_data = CMD_ERASE_SETUP;
                            endcase
                        end
                        default: begin
                            s_data = (op_ff == OP_CHIP_ERASE) ? CMD_CHIP_ERASE : CMD_SECTOR_ERASE;
                            if (op_ff == OP_SECTOR_ERASE) begin
                                // only sector lines matter here
                                s_addr = {tgt_addr_ff[ADDR_W-1:SECTOR_LSB], {SECTOR_LSB{1'b0}}};
                            end
                        end
                    endcase
                    if (op_ff == OP_PROGRAM && step_ff == 3'd3) begin
                        s_addr = tgt_addr_ff;
                    end
                end
            end
        endcase
    end

    // suspend is only legal while a sector erase runs, resume only while suspended
    always_comb begin
        op_ok = 1'b1;
        if (CMD_OP == OP_SUSPEND) begin
            op_ok = erasing_ff && !susp_ff;
        end else if (CMD_OP == OP_RESUME) begin
            op_ok = susp_ff;
        end
    end

    // toggle stopped: bit 6 reads the same on two successive reads
    assign poll_done = have_prev_ff && (prev_ff[TOGGLE_BIT] == FL_DQ_IN[TOGGLE_BIT]);

    // ==========================================================
    // controller
    always_comb begin
        nxt_state     = state_ff;
        nxt_op        = op_ff;
        nxt_step      = step_ff;
        nxt_cnt       = cnt_ff;
        nxt_tgt_addr  = tgt_addr_ff;
        nxt_tgt_data  = tgt_data_ff;
        nxt_prev      = prev_ff;
        nxt_have_prev = have_prev_ff;
        nxt_fail_seen = fail_seen_ff;
        nxt_bypass    = bypass_ff;
        nxt_erasing   = erasing_ff;
        nxt_susp      = susp_ff;
        nxt_done      = 1'b0;
        nxt_fail      = fail_ff;
        nxt_rd        = rd_ff;
        nxt_addr      = addr_ff;
        nxt_dq        = dq_ff;
        nxt_oe        = oe_ff;
        nxt_ce_n      = ce_n_ff;
        nxt_we_n      = we_n_ff;
        nxt_rd_n      = rd_n_ff;
        case (state_ff)
            FWSR_IDLE: begin
                if (CMD_VALID && op_ok) begin
                    nxt_op       = CMD_OP;
                    nxt_tgt_addr = CMD_ADDR;
                    nxt_tgt_data = CMD_DATA;
                    nxt_step     = 3'd0;
                    nxt_fail     = 1'b0;
                    nxt_state    = FWSR_SETUP;
                end
            end
            FWSR_SETUP: begin
                // address and data are set on the same edge that select and strobe fall
                nxt_addr  = s_addr;
                nxt_dq    = {8'h00, s_data};
                if (op_ff == OP_PROGRAM && step_ff == nsteps - 3'd1) begin
                    nxt_dq = tgt_data_ff;
                end
                nxt_oe    = 1'b1;
                nxt_ce_n  = 1'b0;
                nxt_we_n  = 1'b0;
                nxt_cnt   = STROBE_CNT;
                nxt_state = FWSR_STROBE;
            end
            FWSR_STROBE: begin
                if (cnt_ff == CNT_ZERO) begin
                    // strobe rises with data still held
                    nxt_we_n  = 1'b1;
                    nxt_ce_n  = 1'b1;
                    nxt_state = FWSR_HOLD;
                end else begin
                    nxt_cnt = cnt_ff - 4'h1;
                end
            end
            FWSR_HOLD: begin
                nxt_oe = 1'b0;
                if (step_ff == nsteps - 3'd1) begin
                    nxt_have_prev = 1'b0;
                    nxt_fail_seen = 1'b0;
                    case (op_ff)
                        OP_BYPASS_ON:  nxt_bypass = 1'b1;
                        OP_BYPASS_OFF: nxt_bypass = 1'b0;
                        OP_RESET:      nxt_bypass = 1'b0;
                        OP_SECTOR_ERASE, OP_CHIP_ERASE: nxt_erasing = 1'b1;
                        OP_RESUME:     nxt_susp = 1'b0;
                        default: begin
                        end
                    endcase
                    // program, erase, suspend and resume poll; the rest finish now
                    if (op_ff == OP_PROGRAM || op_ff == OP_SECTOR_ERASE || op_ff == OP_CHIP_ERASE ||
                        op_ff == OP_RESUME || op_ff == OP_SUSPEND) begin
                        nxt_state = FWSR_RD_SETUP;
                    end else begin
                        nxt_state = FWSR_DONE;
                    end
                end else begin
                    nxt_step  = step_ff + 3'd1;
                    nxt_state = FWSR_SETUP;
                end
            end
            FWSR_RD_SETUP: begin
                // poll at the program or sector address so bit 7 and sector toggle mean something
                nxt_addr  = tgt_addr_ff;
                nxt_ce_n  = 1'b0;
                nxt_rd_n  = 1'b0;
                nxt_cnt   = STROBE_CNT;
                nxt_state = FWSR_RD_STROBE;
            end
            FWSR_RD_STROBE: begin
                if (cnt_ff == CNT_ZERO) begin
                    nxt_ce_n = 1'b1;
                    nxt_rd_n = 1'b1;
                    nxt_rd   = FL_DQ_IN;
                    nxt_prev = FL_DQ_IN;
                    nxt_have_prev = 1'b1;
                    nxt_state = FWSR_RD_DONE;
                    if (op_ff == OP_SUSPEND) begin
                        // suspended erase: ready high and toggle bit one still
                        if (poll_done && FL_READY_BUSY_N) begin
                            nxt_susp  = 1'b1;
                            nxt_state = FWSR_DONE;
                        end
                    end else if (poll_done) begin
                        // this read shows the toggle bit unchanged since the previous read
                        nxt_erasing = 1'b0;
                        nxt_state   = FWSR_DONE;
                    end else if (fail_seen_ff) begin
                        // still toggling after the fail flag rose: give up and reset
                        nxt_fail    = 1'b1;
                        nxt_erasing = 1'b0;
                        nxt_op      = OP_RESET;
                        nxt_step    = 3'd0;
                        nxt_state   = FWSR_SETUP;
                    end else if (FL_DQ_IN[FAIL_BIT]) begin
                        nxt_fail_seen = 1'b1;
                    end
                end else begin
                    nxt_cnt = cnt_ff - 4'h1;
                end
            end
            FWSR_RD_DONE: begin
                nxt_state = FWSR_RD_SETUP;
                // erase only suspendable between status reads
                if (CMD_VALID && CMD_OP == OP_SUSPEND && (op_ff == OP_SECTOR_ERASE || op_ff == OP_RESUME)) begin
                    nxt_op    = OP_SUSPEND;
                    nxt_step  = 3'd0;
                    nxt_state = FWSR_SETUP;
                end
            end
            FWSR_DONE: begin
                nxt_done  = 1'b1;
                nxt_state = FWSR_IDLE;
            end
            default: begin
                nxt_state = FWSR_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_ff     <= FWSR_IDLE;
            op_ff        <= OP_RESET;
            step_ff      <= 3'd0;
            cnt_ff       <= CNT_ZERO;
            tgt_addr_ff  <= '0;
            tgt_data_ff  <= '0;
            prev_ff      <= '0;
            have_prev_ff <= 1'b0;
            fail_seen_ff <= 1'b0;
            bypass_ff    <= 1'b0;
            erasing_ff   <= 1'b0;
            susp_ff      <= 1'b0;
            done_ff      <= 1'b0;
            fail_ff      <= 1'b0;
            rd_ff        <= '0;
            addr_ff      <= '0;
            dq_ff        <= '0;
            oe_ff        <= 1'b0;
            ce_n_ff      <= 1'b1;
            we_n_ff      <= 1'b1;
            rd_n_ff      <= 1'b1;
        end else begin
            state_ff     <= nxt_state;
            op_ff        <= nxt_op;
            step_ff      <= nxt_step;
            cnt_ff       <= nxt_cnt;
            tgt_addr_ff  <= nxt_tgt_addr;
            tgt_data_ff  <= nxt_tgt_data;
            prev_ff      <= nxt_prev;
            have_prev_ff <= nxt_have_prev;
            fail_seen_ff <= nxt_fail_seen;
            bypass_ff    <= nxt_bypass;
            erasing_ff   <= nxt_erasing;
            susp_ff      <= nxt_susp;
            done_ff      <= nxt_done;
            fail_ff      <= nxt_fail;
            rd_ff        <= nxt_rd;
            addr_ff      <= nxt_addr;
            dq_ff        <= nxt_dq;
            oe_ff        <= nxt_oe;
            ce_n_ff      <= nxt_ce_n;
            we_n_ff      <= nxt_we_n;
            rd_n_ff      <= nxt_rd_n;
        end
    end

    // CMD_READY is registered through state: idle, or between sector erase or resume status reads
    logic ready_ff;
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ready_ff <= 1'b0;
        end else begin
            ready_ff <= (nxt_state == FWSR_IDLE) ||
                        (nxt_state == FWSR_RD_DONE && (nxt_op == OP_SECTOR_ERASE || nxt_op == OP_RESUME));
        end
    end

    assign CMD_READY = ready_ff;
    assign DONE      = done_ff;
    assign FAIL      = fail_ff;
    assign SUSPENDED = susp_ff;
    assign RD_DATA   = rd_ff;
    assign BYPASS_ON = bypass_ff;
    assign FL_ADDR   = addr_ff;
    assign FL_DQ_OUT = dq_ff;
    assign FL_DQ_OE  = oe_ff;
    assign FL_CE_N   = ce_n_ff;
    assign FL_WE_N   = we_n_ff;
    assign FL_OE_N   = rd_n_ff;
endmodule : fwsr_host

// ===== fwsr_pkg.sv
// package for the flash write/status host controller
// assumes a 16-bit parallel flash in word mode outside the chip
package fwsr_pkg;
    localparam int          ADDR_W         = 18;
    localparam int          DATA_W         = 16;
    localparam logic [17:0] UNLOCK_ADDR1   = 18'h00555;
    localparam logic [17:0] UNLOCK_ADDR2   = 18'h002AA;
    localparam logic [7:0]  UNLOCK_DATA1   = 8'hAA;
    localparam logic [7:0]  UNLOCK_DATA2   = 8'h55;
    localparam logic [7:0]  CMD_PROGRAM    = 8'hA0;
    localparam logic [7:0]  CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0]  CMD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0]  CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0]  CMD_RESET      = 8'hF0;
    localparam logic [7:0]  CMD_AUTOSELECT = 8'h90;
    localparam logic [7:0]  CMD_BYPASS     = 8'h20;
    localparam logic [7:0]  CMD_BYPASS_EXIT = 8'h00;
    localparam logic [7:0]  CMD_SUSPEND    = 8'hB0;
    localparam logic [7:0]  CMD_RESUME     = 8'h30;
    localparam int          POLL_BIT       = 7;
    localparam int          TOGGLE_BIT     = 6;
    localparam int          FAIL_BIT       = 5;
    localparam int          WINDOW_BIT     = 3;
    localparam int          SECTOR_TOG_BIT = 2;
    localparam int          SECTOR_LSB     = 12;
    localparam int          STROBE_NS      = 100;
    localparam int          CLK_NS         = 100;
    localparam int          STROBE_CYC     = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0]  STROBE_CNT     = 4'(STROBE_CYC);
    localparam logic [3:0]  CNT_ZERO       = 4'h0;
    localparam logic [2:0]  OP_PROGRAM     = 3'h0;
    localparam logic [2:0]  OP_SECTOR_ERASE = 3'h1;
    localparam logic [2:0]  OP_CHIP_ERASE  = 3'h2;
    localparam logic [2:0]  OP_SUSPEND     = 3'h3;
    localparam logic [2:0]  OP_RESUME      = 3'h4;
    localparam logic [2:0]  OP_RESET       = 3'h5;
    localparam logic [2:0]  OP_BYPASS_ON   = 3'h6;
    localparam logic [2:0]  OP_BYPASS_OFF  = 3'h7;
    typedef enum logic [3:0] {
        FWSR_IDLE, FWSR_SETUP, FWSR_STROBE, FWSR_HOLD,
        FWSR_RD_SETUP, FWSR_RD_STROBE, FWSR_RD_DONE, FWSR_DONE
    } fwsr_state_t;
endpackage : fwsr_pkg

// ===== fwsr_host_props.sv
// checker for fwsr_host: flash pin framing and user handshake
// assumes one CORE_CLK domain; bound onto every fwsr_host instance
module fwsr_host_props
    import fwsr_pkg::*;
(
    input wire logic                        CORE_CLK,
    input wire logic                        RESETN,
    input wire logic                        CMD_READY,
    input wire logic                        DONE,
    input wire logic                        FAIL,
    input wire logic                        SUSPENDED,
    input wire logic                        BYPASS_ON,
    input wire logic [fwsr_pkg::ADDR_W-1:0] FL_ADDR,
    input wire logic [fwsr_pkg::DATA_W-1:0] FL_DQ_OUT,
    input wire logic                        FL_DQ_OE,
    input wire logic                        FL_CE_N,
    input wire logic                        FL_WE_N,
    input wire logic                        FL_OE_N
);
    // ==========================================
    // assertions
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    a_write_has_select: assert property (!FL_WE_N |-> !FL_CE_N) else $error("write strobe without select");
    a_rw_exclusive: assert property (FL_WE_N || FL_OE_N) else $error("write and read strobes overlap");
    a_write_drives_dq: assert property (!FL_WE_N |-> FL_DQ_OE) else $error("write strobe with dq released");
    a_read_floats_dq: assert property (!FL_OE_N |-> !FL_DQ_OE) else $error("dq driven during read");
    a_strobe_two_cyc: assert property ($fell(FL_WE_N) |-> !FL_WE_N[*2] ##1 FL_WE_N)
        else $error("write strobe width wrong");
    a_strobe_stable: assert property (!FL_WE_N && !$past(FL_WE_N) |-> $stable(FL_ADDR) && $stable(FL_DQ_OUT))
        else $error("address or data moved under strobe");
    a_unlock_upper_zero: assert property (!FL_WE_N && FL_ADDR == UNLOCK_ADDR1 && FL_DQ_OUT[7:0] == UNLOCK_DATA1
        |-> FL_DQ_OUT[15:8] == 8'h00) else $error("upper byte set in unlock cycle");
    a_done_single: assert property (DONE |=> !DONE && CMD_READY) else $error("done not a single pulse");
    a_idle_bus_quiet: assert property (CMD_READY |-> FL_CE_N && !FL_DQ_OE) else $error("bus busy while idle");
    // ==========================================
    // covers
    c_fail_done: cover property (DONE && FAIL);
    c_suspend: cover property ($rose(SUSPENDED));
    c_bypass: cover property ($rose(BYPASS_ON));
endmodule : fwsr_host_props
bind fwsr_host fwsr_host_props u_fwsr_host_props (.CORE_CLK, .RESETN, .CMD_READY, .DONE, .FAIL, .SUSPENDED,
    .BYPASS_ON, .FL_ADDR, .FL_DQ_OUT, .FL_DQ_OE, .FL_CE_N, .FL_WE_N, .FL_OE_N);

// ===== fwsr_flash_model.sv
// behavioural flash: command decode and write status bits
// assumes pins change on CORE_CLK; ready/busy pull-up lives in the bench
module fwsr_flash_model
    import fwsr_pkg::*;
#(
    parameter int PROG_READS   = 5,
    parameter int ERASE_CYCLES = 600,
    parameter logic [5:0] PROT_SECTOR = 6'h05
)
(
    input  wire logic                        CORE_CLK,
    input  wire logic                        RESETN,
    input  wire logic [fwsr_pkg::ADDR_W-1:0] FL_ADDR,
    input  wire logic [fwsr_pkg::DATA_W-1:0] FL_DQ_OUT,
    input  wire logic                        FL_CE_N,
    input  wire logic                        FL_WE_N,
    input  wire logic                        FL_OE_N,
    input  wire logic                        FAIL_INJ,
    output logic [fwsr_pkg::DATA_W-1:0]      DQ_DRV,
    output logic                             BUSY_PULL_N
);
    logic [1:0]  mode;     // 0 array, 1 program, 2 erase, 3 suspended
    logic [17:0] pa, wa;
    logic [15:0] pd, wd, arr, last, stat;
    logic [7:0]  prev;
    logic        tog, stog, setup, bypass, pwe, poe;
    int          cnt, resets;
    wire         rd = !FL_CE_N && !FL_OE_N;
    wire         rd_end = !poe && FL_OE_N;
    always_comb begin
        case (mode)
            2'd1: stat = {8'h00, ~pd[7], tog, FAIL_INJ, 5'h00};
            2'd2: stat = {8'h00, 1'b0, tog, 3'b001, stog, 2'b00};
            2'd3: stat = {8'h00, 1'b1, 1'b0, 3'b000, stog, 2'b00};
            default: stat = arr;
        endcase
    end
    // released bus shows the inverse of the last value, no keeper
    assign DQ_DRV = rd ? stat : ~last;
    assign BUSY_PULL_N = !(mode == 2'd1 || mode == 2'd2);
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            mode <= 2'd0; pa <= '0; wa <= '0; pd <= '0; wd <= '0; arr <= '0; last <= '0; prev <= '0;
            tog <= 1'b0; stog <= 1'b0; setup <= 1'b0; bypass <= 1'b0; pwe <= 1'b1; poe <= 1'b1;
            cnt <= 0; resets <= 0;
        end else begin
            pwe <= FL_WE_N;
            poe <= FL_OE_N;
            if (rd) last <= stat;
            if (pwe && !FL_WE_N) wa <= FL_ADDR;
            if (!FL_WE_N) wd <= FL_DQ_OUT;
            if (rd_end && (mode == 2'd1 || mode == 2'd2)) tog <= ~tog;
            if (rd_end && mode[1]) stog <= ~stog;
            if (mode == 2'd2 || (mode == 2'd1 && rd_end && !FAIL_INJ)) cnt <= cnt - 1;
            if ((mode == 2'd1 || mode == 2'd2) && cnt == 0) begin
                mode <= 2'd0;
                arr <= (pa[17:12] == PROT_SECTOR) ? arr : (mode == 2'd1) ? pd : 16'hFFFF;
            end
            if (!pwe && FL_WE_N) begin
                prev <= wd[7:0];
                if (prev == CMD_PROGRAM && mode != 2'd2) begin
                    mode <= 2'd1; pa <= wa; pd <= wd; cnt <= PROG_READS; prev <= 8'h00;
                end else case (wd[7:0])
                    CMD_ERASE_SETUP: setup <= 1'b1;
                    CMD_SECTOR_ERASE, CMD_CHIP_ERASE: begin
                        if (mode == 2'd3 && wd[7:0] == CMD_RESUME) mode <= 2'd2;
                        else if (setup) begin mode <= 2'd2; cnt <= ERASE_CYCLES; setup <= 1'b0; pa <= wa; end
                    end
                    CMD_SUSPEND: if (mode == 2'd2) mode <= 2'd3;
                    CMD_BYPASS: if (prev == UNLOCK_DATA2) bypass <= 1'b1;
                    CMD_BYPASS_EXIT: if (prev == CMD_AUTOSELECT) bypass <= 1'b0;
                    CMD_RESET: begin mode <= 2'd0; setup <= 1'b0; resets <= resets + 1; end
                    default: ;
                endcase
            end
        end
    end
endmodule : fwsr_flash_model

// ===== fwsr_host_test.sv
// self-checking bench: fwsr_host driving the behavioural flash model
// assumes fwsr_host_props bound in; ready/busy pulled up on the wire
module fwsr_host_test;
    timeunit 1ns;
    timeprecision 1ns;
    import fwsr_pkg::*;
    typedef struct {logic [15:0] data; logic [15:0] mask; logic fail;} fwsr_exp_t;
    logic        core_clk = 0, resetn = 0, cmd_valid = 0, fail_inj = 0;
    logic [2:0]  cmd_op = 0;
    logic [17:0] cmd_addr = 0, fl_addr, a;
    logic [15:0] cmd_data = 0, rd_data, dq_out, dq_in, dq_drv, d;
    logic        cmd_ready, done, fail, suspended, bypass_on, dq_oe, ce_n, we_n, oe_n, busy_n;
    int          error_cnt = 0, samples_checked = 0, n0;
    fwsr_exp_t   exp_q[$], e;
    always #50 core_clk = ~core_clk;
    assign dq_in = dq_oe ? dq_out : dq_drv;
    fwsr_host u_fwsr_host (.CORE_CLK(core_clk), .RESETN(resetn), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
        .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data), .CMD_READY(cmd_ready), .DONE(done), .FAIL(fail),
        .SUSPENDED(suspended), .RD_DATA(rd_data), .BYPASS_ON(bypass_on), .FL_ADDR(fl_addr), .FL_DQ_OUT(dq_out),
        .FL_DQ_IN(dq_in), .FL_DQ_OE(dq_oe), .FL_CE_N(ce_n), .FL_WE_N(we_n), .FL_OE_N(oe_n),
        .FL_READY_BUSY_N(busy_n));
    fwsr_flash_model u_fwsr_flash_model (.CORE_CLK(core_clk), .RESETN(resetn), .FL_ADDR(fl_addr),
        .FL_DQ_OUT(dq_out), .FL_CE_N(ce_n), .FL_WE_N(we_n), .FL_OE_N(oe_n), .FAIL_INJ(fail_inj),
        .DQ_DRV(dq_drv), .BUSY_PULL_N(busy_n));
    // ==========================================
    // compare, verdict and driver tasks
    task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    // request held until taken; expectation queued only for completing ops
    task automatic issue(input logic [2:0] op, input logic [17:0] ad, input logic [15:0] dt,
                         input logic [15:0] ed, input logic [15:0] em, input logic ef, input logic w);
        int n;
        if (w) exp_q.push_back('{ed, em, ef});
        cmd_op <= op; cmd_addr <= ad; cmd_data <= dt; cmd_valid <= 1'b1;
        n = 0;
        do begin @(posedge core_clk); n++; end while (cmd_ready !== 1'b1 && n < 50);
        if (cmd_ready !== 1'b1) begin error_cnt++; tally_and_finish(); end
        cmd_valid <= 1'b0;
        n = w ? 0 : 9000;
        while (n < 9000) begin @(posedge core_clk); n++; if (done === 1'b1) break; end
        if (w && n >= 9000) begin error_cnt++; tally_and_finish(); end
        @(posedge core_clk);
    endtask : issue
    task automatic refuse(input logic [2:0] op);
        issue(op, 18'h3F000, 16'h0, 16'h0, 16'h0, 1'b0, 1'b0);
        repeat (12) begin @(posedge core_clk); if (done === 1'b1) cmp(18'h1, 18'h0); end
        cmp(18'(cmd_ready), 18'h1);
    endtask : refuse
    task automatic settle();
        int n;
        for (n = 0; n < 2000 && u_fwsr_flash_model.mode != 2'd0; n++) @(posedge core_clk);
        if (n >= 2000) begin error_cnt++; tally_and_finish(); end
    endtask : settle
    // ==========================================
    // result monitor: oldest note against each completion
    always @(posedge core_clk) begin
        if (done === 1'b1) begin
            if (exp_q.size() == 0) cmp(18'h1, 18'h0);
            else begin
                e = exp_q.pop_front();
                cmp(18'(rd_data & e.mask), 18'(e.data & e.mask));
                cmp(18'(fail), 18'(e.fail));
            end
        end
    end
    // ==========================================
    // main sequence
    initial begin
        void'($urandom(32'h40b90e44));
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge core_clk);
        for (int i = 0; i < 3; i++) begin
            a = {1'b1, 17'($urandom())};
            d = 16'($urandom());
            issue(OP_PROGRAM, a, d, d, 16'hFFFF, 1'b0, 1'b1);
            cmp(u_fwsr_flash_model.pa, a);
            cmp(18'(u_fwsr_flash_model.pd), 18'(d));
        end
        issue(OP_PROGRAM, 18'h05123, ~d, d, 16'hFFFF, 1'b0, 1'b1);
        issue(OP_SECTOR_ERASE, 18'h05000, 16'h0, d, 16'hFFFF, 1'b0, 1'b1);
        $display("test program ended");
        issue(OP_BYPASS_ON, 18'h0, 16'h0, 16'h0, 16'h0, 1'b0, 1'b1);
        cmp(18'({bypass_on, u_fwsr_flash_model.bypass}), 18'h3);
        d = 16'($urandom());
        issue(OP_PROGRAM, a, d, d, 16'hFFFF, 1'b0, 1'b1);
        issue(OP_BYPASS_OFF, 18'h0, 16'h0, 16'h0, 16'h0, 1'b0, 1'b1);
        cmp(18'({bypass_on, u_fwsr_flash_model.bypass}), 18'h0);
        $display("test bypass ended");
        n0 = u_fwsr_flash_model.resets;
        fail_inj <= 1'b1;
        issue(OP_PROGRAM, a, d, 16'h0, 16'h0, 1'b1, 1'b1);
        cmp(18'(u_fwsr_flash_model.resets > n0), 18'h1);
        fail_inj <= 1'b0;
        $display("test fail ended");
        refuse(OP_SUSPEND);
        refuse(OP_RESUME);
        issue(OP_SECTOR_ERASE, 18'h3F000, 16'h0, 16'h0, 16'h0, 1'b0, 1'b0);
        issue(OP_SUSPEND, 18'h3F000, 16'h0, 16'h0080, 16'h00C0, 1'b0, 1'b1);
        cmp(18'({suspended, u_fwsr_flash_model.mode}), 18'h7);
        issue(OP_RESUME, 18'h3F000, 16'h0, 16'hFFFF, 16'hFFFF, 1'b0, 1'b1);
        cmp(18'(suspended), 18'h0);
        cmp(18'(rd_data), 18'hFFFF);
        settle();
        issue(OP_CHIP_ERASE, 18'h0, 16'h0, 16'hFFFF, 16'hFFFF, 1'b0, 1'b1);
        settle();
        cmp(18'(u_fwsr_flash_model.arr), 18'hFFFF);
        $display("test erase ended");
        tally_and_finish();
    end
endmodule : fwsr_host_test
